// ### hdl/tweb_pkg.sv
// tweb_pkg: shared constants for the two-wire eeprom bus-condition ends
// assumes a 10 MHz system clock on both ends
package tweb_pkg;
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned WORD_BITS     = 8;
  localparam int unsigned ACK_SLOT      = 8;      // ninth pulse, counted from zero
  localparam int unsigned RECOVER_PULSES = 9;
  localparam int unsigned WR_TIME_MS    = 10;     // longest self-timed write period
  localparam int unsigned WR_CYCLES     = (CLK_HZ / 1000) * WR_TIME_MS;
  localparam int unsigned SCL_HALF_NS   = 5000;   // controller half period, 100 kHz bus
  localparam int unsigned SCL_HALF_CYC  = (SCL_HALF_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam logic [3:0]  BIT_CNT_RST   = 4'h0;
  localparam logic [2:0]  OP_BYTE       = 3'h1;   // controller command: send byte
  localparam logic [2:0]  OP_READ       = 3'h2;   // controller command: read byte
  localparam logic [2:0]  OP_STOP       = 3'h3;
  localparam logic [2:0]  OP_RECOVER    = 3'h4;
  localparam logic [2:0]  OP_START      = 3'h5;
endpackage : tweb_pkg

// ### hdl/tweb_if.sv
// tweb_if: open-drain two-wire bus between controller and target ends
// assumes both ends pull low with enable low and an external pull-up otherwise
`timescale 1ns/10ps
`default_nettype none
interface tweb_if;
  logic scl_oe_n;     // controller drives scl low when low
  logic sda_ctl_oe_n; // controller pulls sda low when low
  logic sda_tgt_oe_n; // target pulls sda low when low
  logic scl;
  logic sda;
  // sda is a wired-and of both ends with pull-up; scl follows the controller alone
  assign scl = scl_oe_n;
  assign sda = sda_ctl_oe_n & sda_tgt_oe_n;
  modport ctl (output scl_oe_n, output sda_ctl_oe_n, input scl, input sda);
  modport tgt (output sda_tgt_oe_n, input scl, input sda);
endinterface : tweb_if
`default_nettype wire

// ### hdl/tweb_ctl.sv
// tweb_ctl: bus controller end; drives scl from a divider, issues start/stop/bytes/recovery
// assumes one command at a time on i_cmd_valid while o_cmd_ready is high
`timescale 1ns/10ps
`default_nettype none
module tweb_ctl
  import tweb_pkg::*;
#(
  parameter int unsigned HALF_CYC = SCL_HALF_CYC
)(
  // clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_arst_n,
  // command port
  input  wire logic       i_cmd_valid,
  input  wire logic [2:0] i_cmd_op,
  input  wire logic [7:0] i_cmd_data,
  input  wire logic       i_cmd_ack,    // ack to send after a read byte
  output logic            o_cmd_ready,
  output logic            o_done,
  output logic [7:0]      o_rd_data,
  output logic            o_nack,
  // bus
  tweb_if.ctl             bus
);
  typedef enum logic [5:0] {
    C_IDLE = 6'h01, C_START = 6'h02, C_BIT = 6'h04,
    C_STOP = 6'h08, C_RCV = 6'h10, C_FIN = 6'h20
  } tweb_cst_e;
  tweb_cst_e   st_q;
  logic [15:0] div_q;
  logic [1:0]  ph_q;        // quarter phases of one bit
  logic [3:0]  bit_q;
  logic [8:0]  sh_q;
  logic        scl_q, sda_q, rd_q, done_q, nack_q;
  logic [1:0]  sda_s_q;
  logic [7:0]  rd_d_q;
  wire         tick = (div_q == 16'(HALF_CYC / 2));
  wire         sda_in = sda_s_q[1];
  wire         last_bit = (bit_q == 4'(ACK_SLOT));
  assign bus.scl_oe_n     = scl_q;
  assign bus.sda_ctl_oe_n = sda_q;
  assign o_cmd_ready      = (st_q == C_IDLE);
  assign o_done           = done_q;
  assign o_rd_data        = rd_d_q;
  assign o_nack           = nack_q;
  // sda sampler, two flops before use
  always_ff @(posedge i_mclk or negedge i_arst_n)
    if (!i_arst_n) sda_s_q <= 2'h3;
    else sda_s_q <= {sda_s_q[0], bus.sda};
  // quarter-bit divider, the bus clock is made here
  always_ff @(posedge i_mclk or negedge i_arst_n)
    if (!i_arst_n) div_q <= 16'h0;
    else if (st_q == C_IDLE || tick) div_q <= 16'h0;
    else div_q <= div_q + 16'h1;
  // sequencer: data bits move in phase 0 with scl low; start and stop move sda in phase 2 with scl high
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      st_q <= C_IDLE; ph_q <= 2'h0; bit_q <= BIT_CNT_RST; sh_q <= 9'h1ff;
      scl_q <= 1'b1; sda_q <= 1'b1; rd_q <= 1'b0;
      done_q <= 1'b0; nack_q <= 1'b0; rd_d_q <= 8'h0;
    end
    else
    begin
      done_q <= 1'b0;
      case (st_q)
        C_IDLE:
          if (i_cmd_valid)
          begin
            ph_q <= 2'h0; bit_q <= BIT_CNT_RST;
            case (i_cmd_op)
              OP_START:   st_q <= C_START;
              OP_STOP:    st_q <= C_STOP;
              OP_BYTE:    begin sh_q <= {i_cmd_data, 1'b1}; rd_q <= 1'b0; st_q <= C_BIT; end
              OP_READ:    begin sh_q <= {8'hff, ~i_cmd_ack}; rd_q <= 1'b1; st_q <= C_BIT; end
              OP_RECOVER: begin sh_q <= 9'h1ff; st_q <= C_RCV; end
              default:    st_q <= C_IDLE;
            endcase
          end
        // start: sda falls with scl high, then scl falls
        C_START:
          if (tick)
          begin
            ph_q <= ph_q + 2'h1;
            case (ph_q)
              2'h0: begin sda_q <= 1'b1; scl_q <= 1'b0; end
              2'h1: scl_q <= 1'b1;
              2'h2: sda_q <= 1'b0;
              default: begin scl_q <= 1'b0; st_q <= C_FIN; end
            endcase
          end
        // stop: sda rises with scl high
        C_STOP:
          if (tick)
          begin
            ph_q <= ph_q + 2'h1;
            case (ph_q)
              2'h0: begin scl_q <= 1'b0; sda_q <= 1'b0; end
              2'h1: scl_q <= 1'b1;
              2'h2: sda_q <= 1'b1;
              default: st_q <= C_FIN;
            endcase
          end
        // eight data bits then the ack slot, or up to nine recovery pulses with sda released
        C_BIT, C_RCV:
          if (tick)
          begin
            ph_q <= ph_q + 2'h1;
            case (ph_q)
              2'h0: begin scl_q <= 1'b0; sda_q <= (st_q == C_RCV) ? 1'b1 : sh_q[8]; end
              2'h1: scl_q <= 1'b1;
              2'h2:
              begin
                if (st_q == C_BIT && !last_bit && rd_q) rd_d_q <= {rd_d_q[6:0], sda_in};
                if (st_q == C_BIT && last_bit && !rd_q) nack_q <= sda_in;
              end
              default:
              begin
                scl_q <= 1'b0;
                sh_q  <= {sh_q[7:0], 1'b1};
                bit_q <= bit_q + 4'h1;
                // recovery stops early once sda is seen high
                if (st_q == C_RCV && (sda_in || bit_q == 4'(RECOVER_PULSES - 1)))
                  st_q <= C_START;
                else if (st_q == C_BIT && last_bit) st_q <= C_FIN;
              end
            endcase
          end
        C_FIN:
        begin
          sda_q  <= (sda_q | ~scl_q) & sda_q;
          done_q <= 1'b1;
          st_q   <= C_IDLE;
        end
        default: st_q <= C_IDLE;
      endcase
    end
  end
endmodule : tweb_ctl
`default_nettype wire

// ### hdl/tweb_tgt.sv
// tweb_tgt: target end; finds start/stop, frames words, acks, times the internal write
// assumes the bus levels come from another domain and are synchronised here
`timescale 1ns/10ps
`default_nettype none
module tweb_tgt
  import tweb_pkg::*;
#(
  parameter int unsigned WR_CYC = WR_CYCLES
)(
  // clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_arst_n,
  // straps and protection
  input  wire logic [1:0] i_chip_select_straps,
  input  wire logic       i_write_protect,
  // user side: words and status
  output logic            o_start,
  output logic            o_stop,
  output logic            o_word_valid,
  output logic [7:0]      o_word,
  output logic            o_standby,
  output logic            o_write_busy,
  output logic            o_write_commit,
  // bus
  tweb_if.tgt             bus
);
  typedef enum logic [2:0] {
    T_STANDBY = 3'h1,
    T_ACTIVE  = 3'h2,
    T_WRITE   = 3'h4
  } tweb_tst_e;
  tweb_tst_e   st_q;
  logic [1:0]  scl_s_q;
  logic [1:0]  sda_s_q;
  logic [1:0]  wp_s_q;
  logic        scl_p_q;
  logic        sda_p_q;
  logic [3:0]  bit_q;
  logic [7:0]  sh_q;
  logic        ack_q;
  logic        rd_q;
  logic        wr_pend_q;
  logic        first_q;
  logic [31:0] wr_cnt_q;
  logic        start_q;
  logic        stop_q;
  logic        wv_q;
  logic        commit_q;
  logic [7:0]  word_q;
  logic [1:0]  straps_q;
  // edge and condition decoding on synchronised levels
  wire       scl      = scl_s_q[1];
  wire       sda      = sda_s_q[1];
  wire       wp       = wp_s_q[1];
  wire       scl_rise = scl & ~scl_p_q;
  wire       scl_fall = ~scl & scl_p_q;
  wire       start_c  = scl & scl_p_q & sda_p_q & ~sda;
  wire       stop_c   = scl & scl_p_q & ~sda_p_q & sda;
  wire       busy     = (st_q == T_WRITE);
  wire       wr_done  = busy && (wr_cnt_q == WR_CYC - 1);
  // start's own clock fall lands on this value and wraps to bit zero
  wire [3:0] bit_pre  = BIT_CNT_RST - 4'h1;
  assign bus.sda_tgt_oe_n = ~ack_q;
  assign o_start        = start_q;
  assign o_stop         = stop_q;
  assign o_word_valid   = wv_q;
  assign o_word         = word_q;
  assign o_standby      = (st_q == T_STANDBY);
  assign o_write_busy   = busy;
  assign o_write_commit = commit_q;
  // two-flop synchronisers for the bus pins and the protect pin
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      wp_s_q  <= 2'h3;   // protected until the pin is really seen
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end
    else
    begin
      scl_s_q <= {scl_s_q[0], bus.scl};
      sda_s_q <= {sda_s_q[0], bus.sda};
      wp_s_q  <= {wp_s_q[0], i_write_protect};
      scl_p_q <= scl;
      sda_p_q <= sda;
    end
  end
  // straps registered every cycle after reset into straps_q, which drives no output and no address match
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      straps_q <= 2'h0;
    else
      straps_q <= i_chip_select_straps;
  end
  // internal write timer, counted from the stop
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      wr_cnt_q <= 32'h0;
    else if (busy)
      wr_cnt_q <= wr_cnt_q + 32'h1;
    else
      wr_cnt_q <= 32'h0;
  end
  // framing, ack and mode control
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      st_q      <= T_STANDBY;
      bit_q     <= BIT_CNT_RST;
      sh_q      <= 8'h0;
      ack_q     <= 1'b0;
      rd_q      <= 1'b0;
      wr_pend_q <= 1'b0;
      first_q   <= 1'b0;
      start_q   <= 1'b0;
      stop_q    <= 1'b0;
      wv_q      <= 1'b0;
      commit_q  <= 1'b0;
      word_q    <= 8'h0;
    end
    else
    begin
      start_q  <= 1'b0;
      stop_q   <= 1'b0;
      wv_q     <= 1'b0;
      commit_q <= 1'b0;
      case (st_q)
        // bus ignored until programming finishes
        T_WRITE:
          if (wr_done)
          begin
            commit_q <= 1'b1;
            st_q     <= T_STANDBY;
          end
        T_STANDBY, T_ACTIVE:
          if (start_c)
          begin
            // any partial word is dropped
            st_q    <= T_ACTIVE;
            bit_q   <= bit_pre;    // the fall after a start carries no bit
            ack_q   <= 1'b0;
            first_q <= 1'b1;
            rd_q    <= 1'b0;
            start_q <= 1'b1;
          end
          else if (stop_c)
          begin
            ack_q  <= 1'b0;
            stop_q <= 1'b1;
            bit_q  <= BIT_CNT_RST;
            // write period only if bytes landed and not protected
            if (wr_pend_q && !wp && !rd_q)
              st_q <= T_WRITE;
            else
              st_q <= T_STANDBY;
            wr_pend_q <= 1'b0;
          end
          else if (st_q == T_ACTIVE)
          begin
            // bit_pre is above the word size, so nothing is sampled before bit zero
            if (scl_rise && bit_q < 4'(WORD_BITS))
              sh_q <= {sh_q[6:0], sda};
            if (scl_fall)
            begin
              if (bit_q == 4'(WORD_BITS - 1))
              begin
                // ninth pulse: pull low unless reading, released at its falling edge
                ack_q  <= ~rd_q;
                wv_q   <= 1'b1;
                word_q <= sh_q;
                if (first_q)
                  rd_q <= sh_q[0];
                else if (!rd_q)
                  wr_pend_q <= 1'b1;
                first_q <= 1'b0;
                bit_q   <= bit_q + 4'h1;
              end
              else if (bit_q == 4'(ACK_SLOT))
              begin
                ack_q <= 1'b0;
                bit_q <= BIT_CNT_RST;
              end
              else
                bit_q <= bit_q + 4'h1;
            end
          end
        default: st_q <= T_STANDBY;
      endcase
    end
  end
endmodule : tweb_tgt
`default_nettype wire

// ### tb/tweb_asserts.sv
// tweb_asserts: wire-level checks on the two-wire bus joining both ends
// assumes the bench instantiates it beside the interface, same clock and reset
`timescale 1ns/10ps
`default_nettype none
module tweb_asserts #(
  parameter int unsigned HALF_CYC = 8
)(
  // clock and reset
  input  wire logic i_mclk,
  input  wire logic i_arst_n,
  // bus
  input  wire logic i_scl_oe_n,
  input  wire logic i_sda_ctl_oe_n,
  input  wire logic i_sda_tgt_oe_n,
  input  wire logic i_scl,
  input  wire logic i_sda
);
  // short local names for the watched wires
  wire scl_oe_n     = i_scl_oe_n;
  wire sda_ctl_oe_n = i_sda_ctl_oe_n;
  wire sda_tgt_oe_n = i_sda_tgt_oe_n;
  wire scl          = i_scl;
  wire sda          = i_sda;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  logic       scl_q;
  logic       sda_q;
  logic       fr_q;
  logic [7:0] pc_q;
  logic [7:0] ak_q;
  // conditions seen on the raw wires
  wire st = scl && scl_q && sda_q && !sda;
  wire sp = scl && scl_q && !sda_q && sda;
  // wire history, pulses since last condition, ack length
  always_ff @(posedge i_mclk or negedge i_arst_n)
    if (!i_arst_n)
    begin
      {scl_q, sda_q, fr_q, pc_q, ak_q} <= {2'h3, 1'b0, 8'h00, 8'h00};
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
      fr_q  <= st ? 1'b1 : (sp ? 1'b0 : fr_q);
      pc_q  <= (st || sp) ? 8'h00 : pc_q + {7'h00, scl && !scl_q};
      ak_q  <= sda_tgt_oe_n ? 8'h00 : ak_q + 8'h01;
    end
  AST_TGT_LOW_ONLY: assert property ($changed(sda_tgt_oe_n) |-> !scl)
    else $error("target moved sda with clock high");
  AST_ACK_HOLD: assert property ($fell(sda_tgt_oe_n) |-> !sda_tgt_oe_n[*8])
    else $error("ack dropped early");
  AST_ACK_BOUND: assert property (int'(ak_q) < 4 * HALF_CYC)
    else $error("ack held past its pulse");
  AST_ACK_FREE: assert property (!sda_tgt_oe_n && scl |-> sda_ctl_oe_n)
    else $error("controller drove sda in ack slot");
  AST_CTL_HIGH: assert property (scl && scl_q && $changed(sda_ctl_oe_n) |-> ##1 scl ##1 scl)
    else $error("controller data change with clock high");
  AST_START_HOLD: assert property (st |-> scl[*4])
    else $error("start not held");
  AST_STOP_IDLE: assert property (sp |-> (scl && sda && sda_tgt_oe_n)[*4])
    else $error("bus not idle after stop");
  AST_FRAME_BITS: assert property (sp && fr_q |-> pc_q % 9 == 1)
    else $error("frame not whole nine-pulse words");
  AST_RECOVER_MAX: assert property (st && !fr_q |-> pc_q <= 8'h0a)
    else $error("too many clocks before start");
  cover property (st);
  cover property (sp);
  cover property ($fell(sda_tgt_oe_n));
  cover property (st && !fr_q && pc_q > 8'h01);
  cover property (!fr_q && $fell(scl_oe_n) && sda_ctl_oe_n);
endmodule : tweb_asserts
`default_nettype wire

// ### tb/two_wire_eeprom_bus_conditions_tb.sv
// two_wire_eeprom_bus_conditions_tb: controller and target on one bus
// assumes 10 MHz clock, shortened divider and write period
`timescale 1ns/10ps
`default_nettype none
module two_wire_eeprom_bus_conditions_tb;
  import tweb_pkg::*;
  localparam int unsigned HC = 8;
  localparam int unsigned WR = 400;
  logic       i_mclk, i_arst_n, cmd_valid, cmd_ack, wp, ready, done, nack;
  logic       t_start, t_stop, t_wv, standby, busy, commit;
  logic [2:0] cmd_op;
  logic [7:0] cmd_data, rd_data, word;
  int         fails = 0, total_checks = 0, n_start = 0, n_stop = 0, n_word = 0, n_commit = 0, busy_cyc = 0;
  tweb_if bus();
  tweb_ctl #(.HALF_CYC(HC)) tweb_ctl_i (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_cmd_valid(cmd_valid),
    .i_cmd_op(cmd_op), .i_cmd_data(cmd_data), .i_cmd_ack(cmd_ack), .o_cmd_ready(ready), .o_done(done),
    .o_rd_data(rd_data), .o_nack(nack), .bus(bus.ctl));
  tweb_tgt #(.WR_CYC(WR)) tweb_tgt_i (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_chip_select_straps(2'h0),
    .i_write_protect(wp), .o_start(t_start), .o_stop(t_stop), .o_word_valid(t_wv), .o_word(word),
    .o_standby(standby), .o_write_busy(busy), .o_write_commit(commit), .bus(bus.tgt));
  tweb_asserts #(.HALF_CYC(HC)) tweb_asserts_i (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
    .i_scl_oe_n(bus.scl_oe_n), .i_sda_ctl_oe_n(bus.sda_ctl_oe_n), .i_sda_tgt_oe_n(bus.sda_tgt_oe_n),
    .i_scl(bus.scl), .i_sda(bus.sda));
  // clock
  initial
  begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end
  // pulse counters and a busy-cycle count on the target user side, read mid-cycle away from the launching edge
  always @(negedge i_mclk)
  begin
    n_start  += t_start;
    n_stop   += t_stop;
    n_word   += t_wv;
    n_commit += commit;
    busy_cyc += busy;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(negedge i_mclk);
  endtask : idle
  // one command, valid held over the taking edge, bounded wait for done
  task automatic cmd(input logic [2:0] op, input logic [7:0] d, input logic a);
    int n;
    n = 0;
    @(negedge i_mclk);
    {cmd_op, cmd_data, cmd_ack, cmd_valid} = {op, d, a, 1'b1};
    @(negedge i_mclk);
    cmd_valid = 1'b0;
    while (done !== 1'b1 && n < 2000)
    begin
      @(negedge i_mclk);
      n++;
    end
    if (n >= 2000) fails++;
  endtask : cmd
  task automatic tally_and_finish;
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  // hang guard, a few times the expected run
  initial
  begin
    #2_000_000;
    fails++;
    tally_and_finish();
  end
  // main sequence
  initial
  begin : main
    int s, w;
    {cmd_valid, cmd_ack, wp, cmd_op, cmd_data, i_arst_n} = '0;
    idle(4);
    i_arst_n = 1'b1;
    chk(standby, 1);
    $display("test reset done");
    w = n_word;
    cmd(OP_START, 8'h00, 1'b0);
    cmd(OP_BYTE, 8'ha0, 1'b0);
    chk(nack, 0);
    chk(word, 8'ha0);
    cmd(OP_BYTE, 8'h5a, 1'b0);
    chk(word, 8'h5a);
    chk(n_word - w, 2);
    s = n_stop;
    cmd(OP_STOP, 8'h00, 1'b0);
    idle(6);
    chk(n_stop - s, 1);
    chk(busy, 1);
    chk(standby, 0);
    s = n_start;
    cmd(OP_START, 8'h00, 1'b0);
    cmd(OP_BYTE, 8'ha0, 1'b0);
    chk(nack, 1);
    chk(n_start - s, 0);
    s = n_commit;
    w = 0;
    while (n_commit == s && w < 2 * WR)
    begin
      idle(1);
      w++;
    end
    chk(n_commit - s, 1);
    chk(busy_cyc <= WR, 1);
    idle(2);
    chk(standby, 1);
    cmd(OP_STOP, 8'h00, 1'b0);
    $display("test write done");
    s = n_start;
    cmd(OP_START, 8'h00, 1'b0);
    cmd(OP_BYTE, 8'ha0, 1'b0);
    cmd(OP_START, 8'h00, 1'b0);
    cmd(OP_BYTE, 8'ha1, 1'b0);
    chk(n_start - s, 2);
    chk(word, 8'ha1);
    cmd(OP_READ, 8'h00, 1'b0);
    chk(rd_data, 8'hff);
    cmd(OP_STOP, 8'h00, 1'b0);
    idle(6);
    chk(standby, 1);
    chk(busy, 0);
    $display("test read done");
    wp = 1'b1;
    s = n_commit;
    cmd(OP_START, 8'h00, 1'b0);
    cmd(OP_BYTE, 8'ha0, 1'b0);
    cmd(OP_BYTE, 8'h33, 1'b0);
    cmd(OP_STOP, 8'h00, 1'b0);
    idle(6);
    chk(busy, 0);
    idle(WR);
    chk(n_commit - s, 0);
    wp = 1'b0;
    $display("test protect done");
    s = n_start;
    cmd(OP_RECOVER, 8'h00, 1'b0);
    idle(6);
    chk(n_start - s, 1);
    cmd(OP_BYTE, 8'ha0, 1'b0);
    chk(nack, 0);
    cmd(OP_STOP, 8'h00, 1'b0);
    $display("test recover done");
    tally_and_finish();
  end
endmodule : two_wire_eeprom_bus_conditions_tb
`default_nettype wire
